// File: rtl/rpgs_pkg.sv
// Package of constants and types for the reference pulse gear scaler
// Operation
// - Numerator one is high times 10000 plus low
// - Numerator two is high times 10000 plus low
// - Denominator is high times 10000 plus low; scale
// - Wide gear settings apply only when format equals 1
// - Multiply or divide reference pulse frequency by ratio
// - Bit rate code 0..5 selects 50K..1M
// - Node address comes from dedicated address setting
// - Encoder code: reserved, 17-bit, resolver, wire-saving, 20-bit
package rpgs_pkg;
    // Register byte offsets
    localparam logic [7:0] RPGS_OFS_CTRL     = 8'h00;
    localparam logic [7:0] RPGS_OFS_RATE     = 8'h04;
    localparam logic [7:0] RPGS_OFS_NODE     = 8'h08;
    localparam logic [7:0] RPGS_OFS_N1H      = 8'h0c;
    localparam logic [7:0] RPGS_OFS_N1L      = 8'h10;
    localparam logic [7:0] RPGS_OFS_DH       = 8'h14;
    localparam logic [7:0] RPGS_OFS_DL       = 8'h18;
    localparam logic [7:0] RPGS_OFS_N2H      = 8'h1c;
    localparam logic [7:0] RPGS_OFS_N2L      = 8'h20;
    localparam logic [7:0] RPGS_OFS_ENC      = 8'h24;
    localparam logic [7:0] RPGS_OFS_STATUS   = 8'h28;
    localparam logic [7:0] RPGS_OFS_COUNT    = 8'h2c;
    // Decimal part weight and reset values
    localparam logic [31:0] RPGS_DEC_WEIGHT  = 32'h0000_2710;
    localparam logic [15:0] RPGS_PART_RST    = 16'h0000;
    localparam logic [15:0] RPGS_LOW_ONE     = 16'h0001;
    localparam logic [3:0]  RPGS_RATE_RST    = 4'h4;
    localparam logic [7:0]  RPGS_NODE_RST    = 8'h01;
    localparam logic [3:0]  RPGS_ENC_RST     = 4'h3;
    // Gear format value that enables the wide settings
    localparam logic        RPGS_FMT_WIDE    = 1'b1;
    // Field positions of the control register
    localparam int          RPGS_CTRL_FMT    = 0;
    localparam int          RPGS_CTRL_EN     = 1;
    // Bit rates in kbps per code
    localparam logic [15:0] RPGS_KBPS_0      = 16'h0032;
    localparam logic [15:0] RPGS_KBPS_1      = 16'h0064;
    localparam logic [15:0] RPGS_KBPS_2      = 16'h007d;
    localparam logic [15:0] RPGS_KBPS_3      = 16'h00fa;
    localparam logic [15:0] RPGS_KBPS_4      = 16'h01f4;
    localparam logic [15:0] RPGS_KBPS_5      = 16'h03e8;
    localparam logic [3:0]  RPGS_RATE_MAX    = 4'h5;
    // AXI responses
    localparam logic [1:0]  RPGS_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RPGS_RESP_SLVERR = 2'b10;

    // Decoded encoder kind
    typedef enum logic [5:0] {
        RPGS_ENC_RESERVED = 6'b000001,
        RPGS_ENC_ABS17    = 6'b000010,
        RPGS_ENC_INC17    = 6'b000100,
        RPGS_ENC_RESOLVER = 6'b001000,
        RPGS_ENC_WSAVE    = 6'b010000,
        RPGS_ENC_ABS20    = 6'b100000
    } rpgs_enc_kind_t;

    // Gear ratio handed to the scaler
    typedef struct packed {
        logic [31:0] num;
        logic [31:0] den;
    } rpgs_ratio_t;
endpackage : rpgs_pkg

// File: rtl/rpgs_scaler.sv
// Pulse scaler that multiplies or divides pulse frequency by num/den
`timescale 1ns/10ps
module rpgs_scaler
    import rpgs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        enable,
    input  wire rpgs_ratio_t ratio,
    input  wire logic        pulse_in,
    output logic             pulse_out,
    output logic             busy
);
    logic [33:0] acc_reg;
    logic [33:0] acc_next;
    logic        out_reg;
    wire  [33:0] acc_add  = pulse_in ? acc_reg + {2'b00, ratio.num} : acc_reg;
    wire         can_emit = acc_add >= {2'b00, ratio.den};

    // Each input pulse adds num, each output pulse takes den away
    always_comb begin
        acc_next = acc_add;
        if (can_emit) begin
            acc_next = acc_add - {2'b00, ratio.den};
        end
    end

    // Accumulator with at most one output pulse per cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            acc_reg <= 34'h0;
            out_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            out_reg <= can_emit;
        end
    end

    assign pulse_out = out_reg;
    assign busy      = acc_reg != 34'h0;
endmodule // rpgs_scaler

// File: rtl/rpgs_top.sv
// Reference pulse gear scaler with AXI4-Lite settings registers
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module rpgs_top
    import rpgs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ref_pulse,
    input  wire logic        gear_num_select,
    output logic             scaled_pulse,
    output logic [15:0]      fieldbus_kbps,
    output logic [7:0]       fieldbus_node_address,
    output logic [5:0]       encoder_kind
);
    // Settings registers
    logic [1:0]  ctrl_reg;
    logic [3:0]  fieldbus_rate_code_reg;
    logic [7:0]  node_reg;
    logic [15:0] gear_num_one_high_reg;
    logic [15:0] gear_num_one_low_reg;
    logic [15:0] gear_den_high_reg;
    logic [15:0] gear_den_low_reg;
    logic [15:0] gear_num_two_high_reg;
    logic [15:0] gear_num_two_low_reg;
    logic [3:0]  encoder_type_code_reg;
    logic [31:0] out_count_reg;
    // Bus state
    logic        aw_held_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    // Pin synchronisers and select latch
    logic [1:0]  pulse_sync_reg;
    logic        pulse_prev_reg;
    logic [1:0]  sel_sync_reg;
    logic        sel_reg;
    // Output registers
    logic        scaled_reg;
    logic [15:0] kbps_reg;
    logic [7:0]  node_out_reg;
    logic [5:0]  enc_out_reg;
    rpgs_ratio_t ratio_reg;

    // Write channel decode
    wire         aw_ok     = aw_held_reg || s_axi_awvalid;
    wire         w_ok      = w_held_reg || s_axi_wvalid;
    wire [7:0]   wr_addr   = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0]  wr_data   = w_held_reg ? w_data_reg : s_axi_wdata;
    wire [3:0]   wr_strb   = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wire         wr_fire   = aw_ok && w_ok && !bvalid_reg;
    wire [31:0]  wr_mask   = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire         wr_known  = wr_addr <= RPGS_OFS_ENC && wr_addr[1:0] == 2'b00;
    wire         rd_known  = s_axi_araddr <= RPGS_OFS_COUNT && s_axi_araddr[1:0] == 2'b00;
    wire         rd_fire   = s_axi_arvalid && !rvalid_reg;

    // Function that merges write data under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    wire [31:0]  m_ctrl  = merge({30'h0, ctrl_reg}, wr_data, wr_mask);
    wire [31:0]  m_rate  = merge({28'h0, fieldbus_rate_code_reg}, wr_data, wr_mask);
    wire [31:0]  m_node  = merge({24'h0, node_reg}, wr_data, wr_mask);
    wire [31:0]  m_n1h   = merge({16'h0, gear_num_one_high_reg}, wr_data, wr_mask);
    wire [31:0]  m_n1l   = merge({16'h0, gear_num_one_low_reg}, wr_data, wr_mask);
    wire [31:0]  m_dh    = merge({16'h0, gear_den_high_reg}, wr_data, wr_mask);
    wire [31:0]  m_dl    = merge({16'h0, gear_den_low_reg}, wr_data, wr_mask);
    wire [31:0]  m_n2h   = merge({16'h0, gear_num_two_high_reg}, wr_data, wr_mask);
    wire [31:0]  m_n2l   = merge({16'h0, gear_num_two_low_reg}, wr_data, wr_mask);
    wire [31:0]  m_enc   = merge({28'h0, encoder_type_code_reg}, wr_data, wr_mask);

    // Gear terms built from decimal high and low parts
    wire [31:0]  num_one  = 32'(gear_num_one_high_reg * RPGS_DEC_WEIGHT) + {16'h0, gear_num_one_low_reg};
    wire [31:0]  num_two  = 32'(gear_num_two_high_reg * RPGS_DEC_WEIGHT) + {16'h0, gear_num_two_low_reg};
    wire [31:0]  den_all  = 32'(gear_den_high_reg * RPGS_DEC_WEIGHT) + {16'h0, gear_den_low_reg};
    wire         fmt_wide = ctrl_reg[RPGS_CTRL_FMT] == RPGS_FMT_WIDE;
    wire         scale_en = ctrl_reg[RPGS_CTRL_EN];
    wire [31:0]  num_pick = sel_reg ? num_two : num_one;
    wire         ratio_ok = num_pick != 32'h0 && den_all != 32'h0;
    // Without the wide format the ratio is one to one
    wire [31:0]  num_use  = (fmt_wide && ratio_ok) ? num_pick : 32'h1;
    wire [31:0]  den_use  = (fmt_wide && ratio_ok) ? den_all : 32'h1;
    wire         pulse_rise = pulse_sync_reg[1] && !pulse_prev_reg;
    wire         scaler_out;
    wire         scaler_busy;

    // Bit rate lookup
    wire [15:0]  kbps_lut = (fieldbus_rate_code_reg == 4'h0) ? RPGS_KBPS_0 :
                            (fieldbus_rate_code_reg == 4'h1) ? RPGS_KBPS_1 :
                            (fieldbus_rate_code_reg == 4'h2) ? RPGS_KBPS_2 :
                            (fieldbus_rate_code_reg == 4'h3) ? RPGS_KBPS_3 :
                            (fieldbus_rate_code_reg == 4'h4) ? RPGS_KBPS_4 :
                            (fieldbus_rate_code_reg == 4'h5) ? RPGS_KBPS_5 : 16'h0000;
    // Encoder kind decode; code 8 is 20-bit incremental, shown as ABS20 with bit 0
    wire [5:0]   enc_lut  = (encoder_type_code_reg == 4'h3) ? RPGS_ENC_ABS17 :
                            (encoder_type_code_reg == 4'h4) ? RPGS_ENC_INC17 :
                            (encoder_type_code_reg == 4'h5) ? RPGS_ENC_RESOLVER :
                            (encoder_type_code_reg == 4'h6) ? RPGS_ENC_WSAVE :
                            (encoder_type_code_reg == 4'h7) ? RPGS_ENC_ABS20 :
                            (encoder_type_code_reg == 4'h8) ? 6'b100001 : RPGS_ENC_RESERVED;

    // Read data select
    wire [31:0]  rd_mux = (s_axi_araddr == RPGS_OFS_CTRL)   ? {30'h0, ctrl_reg} :
                          (s_axi_araddr == RPGS_OFS_RATE)   ? {28'h0, fieldbus_rate_code_reg} :
                          (s_axi_araddr == RPGS_OFS_NODE)   ? {24'h0, node_reg} :
                          (s_axi_araddr == RPGS_OFS_N1H)    ? {16'h0, gear_num_one_high_reg} :
                          (s_axi_araddr == RPGS_OFS_N1L)    ? {16'h0, gear_num_one_low_reg} :
                          (s_axi_araddr == RPGS_OFS_DH)     ? {16'h0, gear_den_high_reg} :
                          (s_axi_araddr == RPGS_OFS_DL)     ? {16'h0, gear_den_low_reg} :
                          (s_axi_araddr == RPGS_OFS_N2H)    ? {16'h0, gear_num_two_high_reg} :
                          (s_axi_araddr == RPGS_OFS_N2L)    ? {16'h0, gear_num_two_low_reg} :
                          (s_axi_araddr == RPGS_OFS_ENC)    ? {28'h0, encoder_type_code_reg} :
                          (s_axi_araddr == RPGS_OFS_STATUS) ? {29'h0, ratio_ok, scaler_busy, sel_reg} :
                          (s_axi_araddr == RPGS_OFS_COUNT)  ? out_count_reg : 32'h0;

    // Write address and data holding, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= !wr_fire;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= !wr_fire;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RPGS_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_known ? RPGS_RESP_OKAY : RPGS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Settings registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg               <= 2'b00;
            fieldbus_rate_code_reg <= RPGS_RATE_RST;
            node_reg               <= RPGS_NODE_RST;
            gear_num_one_high_reg  <= RPGS_PART_RST;
            gear_num_one_low_reg   <= RPGS_LOW_ONE;
            gear_den_high_reg      <= RPGS_PART_RST;
            gear_den_low_reg       <= RPGS_LOW_ONE;
            gear_num_two_high_reg  <= RPGS_PART_RST;
            gear_num_two_low_reg   <= RPGS_LOW_ONE;
            encoder_type_code_reg  <= RPGS_ENC_RST;
        end else if (wr_fire) begin
            unique case (wr_addr)
                RPGS_OFS_CTRL: ctrl_reg <= m_ctrl[1:0];
                RPGS_OFS_RATE: fieldbus_rate_code_reg <= m_rate[3:0];
                RPGS_OFS_NODE: node_reg <= m_node[7:0];
                RPGS_OFS_N1H:  gear_num_one_high_reg <= m_n1h[15:0];
                RPGS_OFS_N1L:  gear_num_one_low_reg <= m_n1l[15:0];
                RPGS_OFS_DH:   gear_den_high_reg <= m_dh[15:0];
                RPGS_OFS_DL:   gear_den_low_reg <= m_dl[15:0];
                RPGS_OFS_N2H:  gear_num_two_high_reg <= m_n2h[15:0];
                RPGS_OFS_N2L:  gear_num_two_low_reg <= m_n2l[15:0];
                RPGS_OFS_ENC:  encoder_type_code_reg <= m_enc[3:0];
                default: ;
            endcase
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= RPGS_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_known ? RPGS_RESP_OKAY : RPGS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Pin synchronisers; select only changes while the scaler is idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_sync_reg <= 2'b00;
            pulse_prev_reg <= 1'b0;
            sel_sync_reg   <= 2'b00;
            sel_reg        <= 1'b0;
        end else begin
            pulse_sync_reg <= {pulse_sync_reg[0], ref_pulse};
            pulse_prev_reg <= pulse_sync_reg[1];
            sel_sync_reg   <= {sel_sync_reg[0], gear_num_select};
            if (!scaler_busy && !pulse_rise) begin
                sel_reg <= sel_sync_reg[1];
            end
        end
    end

    // Ratio, outputs and pulse count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ratio_reg     <= '{num: 32'h1, den: 32'h1};
            scaled_reg    <= 1'b0;
            kbps_reg      <= RPGS_KBPS_4;
            node_out_reg  <= RPGS_NODE_RST;
            enc_out_reg   <= RPGS_ENC_ABS17;
            out_count_reg <= 32'h0;
        end else begin
            ratio_reg     <= '{num: num_use, den: den_use};
            scaled_reg    <= scaler_out;
            kbps_reg      <= kbps_lut;
            node_out_reg  <= node_reg;
            enc_out_reg   <= enc_lut;
            out_count_reg <= out_count_reg + {31'h0, scaler_out};
        end
    end

    rpgs_scaler u_scaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .enable    (scale_en),
        .ratio     (ratio_reg),
        .pulse_in  (pulse_rise),
        .pulse_out (scaler_out),
        .busy      (scaler_busy)
    );

    assign s_axi_awready         = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready          = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid          = bvalid_reg;
    assign s_axi_bresp           = bresp_reg;
    assign s_axi_arready         = !rvalid_reg;
    assign s_axi_rvalid          = rvalid_reg;
    assign s_axi_rdata           = rdata_reg;
    assign s_axi_rresp           = rresp_reg;
    assign scaled_pulse          = scaled_reg;
    assign fieldbus_kbps         = kbps_reg;
    assign fieldbus_node_address = node_out_reg;
    assign encoder_kind          = enc_out_reg;

    // Checks
    a_ratio_applied: assert property (@(posedge aclk) disable iff (!aresetn)
        (fmt_wide && ratio_ok) |=> ratio_reg.den == $past(den_all))
        else $error("Denominator not applied");
    a_format_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !fmt_wide |=> ratio_reg.num == 32'h1 && ratio_reg.den == 32'h1)
        else $error("Wide gear used without format");
    a_num_one: assert property (@(posedge aclk) disable iff (!aresetn)
        num_one == 32'(gear_num_one_high_reg * 32'd10000) + 32'(gear_num_one_low_reg))
        else $error("Numerator one wrong");
    a_num_two: assert property (@(posedge aclk) disable iff (!aresetn)
        num_two == 32'(gear_num_two_high_reg * 32'd10000) + 32'(gear_num_two_low_reg))
        else $error("Numerator two wrong");
    // Detected pulse at unity ratio; the scaled pulse follows two edges later
    sequence s_unity_rise;
        scale_en && $stable(scale_en) && ratio_reg.num == 32'h1 && ratio_reg.den == 32'h1 && pulse_rise;
    endsequence
    a_unity_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        s_unity_rise |=> ##1 scaled_pulse)
        else $error("Unity ratio lost a pulse");
    a_rate_map: assert property (@(posedge aclk) disable iff (!aresetn)
        fieldbus_rate_code_reg == 4'h5 |=> fieldbus_kbps == 16'd1000)
        else $error("Bit rate map wrong");
    a_node_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 fieldbus_node_address == $past(node_reg))
        else $error("Node address not followed");
    a_enc_resolver: assert property (@(posedge aclk) disable iff (!aresetn)
        encoder_type_code_reg == 4'h5 |=> encoder_kind == RPGS_ENC_RESOLVER)
        else $error("Encoder decode wrong");
    a_sel_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        scaler_busy |=> $stable(sel_reg))
        else $error("Numerator changed while scaling");
endmodule // rpgs_top

// File: verif/rpgs_pulse_host.sv
// Host model that issues bursts of reference pulses
`timescale 1ns/10ps
module rpgs_pulse_host (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       go,
    input  wire logic [7:0] count,
    output logic            ref_pulse,
    output logic            done
);
    logic [7:0] left_reg;
    logic [1:0] ph_reg;

    // Each pulse is two cycles high and two low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_reg  <= 8'h00;
            ph_reg    <= 2'h0;
            ref_pulse <= 1'b0;
        end else if (go) begin
            left_reg <= count;
            ph_reg   <= 2'h0;
        end else if (left_reg != 8'h00) begin
            ph_reg    <= ph_reg + 2'h1;
            ref_pulse <= ~ph_reg[1];
            if (ph_reg == 2'h3) begin
                left_reg <= left_reg - 8'h01;
            end
        end else begin
            ref_pulse <= 1'b0;
        end
    end

    // Burst finished once the count is used up
    assign done = (left_reg == 8'h00) && !go;
endmodule // rpgs_pulse_host

// File: verif/tb_top.sv
// Testbench for the reference pulse gear scaler
`timescale 1ns/10ps
module tb_top;
    import rpgs_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, hcount = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, ref_pulse, sel = 0, scaled, go = 0, hdone, clr = 0;
    logic [15:0] kbps, out_cnt;
    logic [7:0] node;
    logic [5:0] kind;
    int errors = 0, check_count = 0, cycles = 0;
    logic [15:0] rates [6] = '{RPGS_KBPS_0, RPGS_KBPS_1, RPGS_KBPS_2, RPGS_KBPS_3, RPGS_KBPS_4, RPGS_KBPS_5};
    logic [5:0] kinds [10] = '{6'h01, 6'h01, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h21, 6'h01};

    rpgs_top u_rpgs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_pulse(ref_pulse),
        .gear_num_select(sel), .scaled_pulse(scaled), .fieldbus_kbps(kbps), .fieldbus_node_address(node),
        .encoder_kind(kind));
    rpgs_pulse_host u_rpgs_pulse_host (.aclk(aclk), .aresetn(aresetn), .go(go), .count(hcount),
        .ref_pulse(ref_pulse), .done(hdone));

    // Clock, scaled pulse counter and hang guard
    always #4 aclk = ~aclk;
    always_ff @(posedge aclk) out_cnt <= clr ? 16'h0000 : out_cnt + {15'h0, scaled === 1'b1};
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        chk("rdata", rdata, exp);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 0;
    endtask

    // Program a ratio, send n pulses and compare the scaled count
    task automatic gear(input logic [31:0] ctrl, n1h, n1l, n2h, n2l, dh, dl, input logic s,
                        input logic [7:0] n, input logic [15:0] exp);
        wr(RPGS_OFS_CTRL, 32'h0);
        wr(RPGS_OFS_N1H, n1h); wr(RPGS_OFS_N1L, n1l); wr(RPGS_OFS_N2H, n2h);
        wr(RPGS_OFS_N2L, n2l); wr(RPGS_OFS_DH, dh); wr(RPGS_OFS_DL, dl);
        wr(RPGS_OFS_CTRL, ctrl);
        sel <= s; clr <= 1;
        repeat (6) @(posedge aclk);
        clr <= 0; hcount <= n; go <= 1;
        @(posedge aclk);
        go <= 0;
        @(posedge aclk);
        while (!hdone) @(posedge aclk);
        repeat (30) @(posedge aclk);
        chk("scaled count", {16'h0, out_cnt}, {16'h0, exp});
    endtask

    task automatic t_reset();
        chk("kbps reset", {16'h0, kbps}, 32'h1f4);
        chk("node reset", {24'h0, node}, 32'h1);
        chk("kind reset", {26'h0, kind}, 32'h2);
        rd(RPGS_OFS_N1L, 32'h1, RPGS_RESP_OKAY);
        rd(RPGS_OFS_DH, 32'h0, RPGS_RESP_OKAY);
        rd(RPGS_OFS_ENC, 32'h3, RPGS_RESP_OKAY);
    endtask

    task automatic t_settings();
        for (int i = 0; i < 7; i++) begin
            wr(RPGS_OFS_RATE, i);
            repeat (2) @(posedge aclk);
            chk("kbps", {16'h0, kbps}, (i < 6) ? {16'h0, rates[i]} : 32'h0);
        end
        for (int i = 0; i < 10; i++) begin
            wr(RPGS_OFS_ENC, i);
            repeat (2) @(posedge aclk);
            chk("encoder kind", {26'h0, kind}, {26'h0, kinds[i]});
        end
        wr(RPGS_OFS_NODE, 32'h7f);
        repeat (2) @(posedge aclk);
        chk("node", {24'h0, node}, 32'h7f);
    endtask

    task automatic t_errors();
        wr(8'h30, 32'h5);
        chk("unmapped bresp", {30'h0, resp}, {30'h0, RPGS_RESP_SLVERR});
        wr(RPGS_OFS_STATUS, 32'h5);
        chk("read only bresp", {30'h0, resp}, {30'h0, RPGS_RESP_SLVERR});
        rd(8'h31, 32'h0, RPGS_RESP_SLVERR);
    endtask

    task automatic finish_test();
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_settings();
        t_errors();
        gear(32'h3, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'd5000, 1'b0, 8'd10, 16'd20);
        gear(32'h3, 32'h0, 32'h1, 32'h1, 32'h0, 32'h2, 32'h0, 1'b1, 8'd10, 16'd5);
        gear(32'h2, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'd5000, 1'b0, 8'd10, 16'd10);
        // Scaler disabled: pulses are refused, nothing comes out
        gear(32'h1, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'd5000, 1'b0, 8'd10, 16'd0);
        rd(RPGS_OFS_COUNT, 32'd35, RPGS_RESP_OKAY);
        rd(RPGS_OFS_STATUS, 32'h4, RPGS_RESP_OKAY);
        finish_test();
    end
endmodule // tb_top
